// >>> design/fidj_exec.sv
// Execution unit for decrement, increment, decrement-skip and jump.
// Fetches instr_i at pc_o during the decode phase; the register file
// answers reg_rd_data_i combinationally for reg_addr_o during the read phase.
`timescale 1ns/1ps
module fidj_exec
  import fidj_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  input  wire logic [INSTR_W-1:0]   instr_i,
  input  wire logic [LATCH_W-1:0]   program_counter_high_latch_i,
  input  wire logic [DATA_W-1:0]    reg_rd_data_i,
  output logic      [PC_W-1:0]      pc_o,
  output logic      [PHASE_W-1:0]   phase_o,
  output logic      [ADDR_W-1:0]    reg_addr_o,
  output logic                      reg_wr_en_o,
  output logic                      w_wr_en_o,
  output logic      [DATA_W-1:0]    result_o,
  output logic                      z_o,
  output logic                      z_wr_en_o,
  output logic                      nop_cycle_o
);

  logic [PHASE_W-1:0] phase;
  logic               last_phase;

  fidj_phase_seq #(
    .PHASES (PHASE_COUNT),
    .PW     (PHASE_W)
  ) u_phase (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .phase_o (phase),
    .last_o  (last_phase)
  );

  // Instruction, decode and pipeline state
  logic [INSTR_W-1:0] ir;
  logic [INSTR_W-1:0] next_ir;
  fidj_op_t           op;
  fidj_op_t           next_op;
  logic               nop_cycle;
  logic               next_nop_cycle;
  logic               flush;
  logic               next_flush;

  // Datapath state
  logic [DATA_W-1:0]  operand;
  logic [DATA_W-1:0]  next_operand;
  logic [DATA_W-1:0]  result;
  logic [DATA_W-1:0]  next_result;
  logic               zero;
  logic               next_zero;
  logic               reg_wr_en;
  logic               next_reg_wr_en;
  logic               w_wr_en;
  logic               next_w_wr_en;
  logic               z_wr_en;
  logic               next_z_wr_en;
  logic [PC_W-1:0]    pc;
  logic [PC_W-1:0]    next_pc;

  function automatic fidj_op_t decode_op(input logic [INSTR_W-1:0] word);
    fidj_op_t kind;
    kind = FIDJ_OP_NONE;
    if (word[OPC_HI:JMP_OPC_LO] == OPC_JUMP) begin
      kind = FIDJ_OP_JUMP;
    end else if (word[OPC_HI:OPC_LO] == OPC_DEC) begin
      kind = FIDJ_OP_DEC;
    end else if (word[OPC_HI:OPC_LO] == OPC_INC) begin
      kind = FIDJ_OP_INC;
    end else if (word[OPC_HI:OPC_LO] == OPC_DEC_SKIP) begin
      kind = FIDJ_OP_DEC_SKIP;
    end
    return kind;
  endfunction

  wire logic dest_loc = (ir[DEST_BIT] == DEST_LOC);

  // Instruction register and decode; a flushed cycle runs as a no-operation
  always_comb begin
    next_ir        = ir;
    next_op        = op;
    next_nop_cycle = nop_cycle;
    if (ce_i && phase == PH_DECODE) begin
      if (flush) begin
        next_ir        = RST_INSTR;
        next_op        = FIDJ_OP_NONE;
        next_nop_cycle = 1'b1;
      end else begin
        next_ir        = instr_i;
        next_op        = decode_op(instr_i);
        next_nop_cycle = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ir        <= RST_INSTR;
      op        <= FIDJ_OP_NONE;
      nop_cycle <= 1'b0;
    end else begin
      ir        <= next_ir;
      op        <= next_op;
      nop_cycle <= next_nop_cycle;
    end
  end

  // Read, process and write phases
  always_comb begin
    next_operand   = operand;
    next_result    = result;
    next_zero      = zero;
    next_reg_wr_en = reg_wr_en;
    next_w_wr_en   = w_wr_en;
    next_z_wr_en   = z_wr_en;
    if (ce_i) begin
      unique case (phase)
        PH_DECODE: begin
          next_reg_wr_en = 1'b0;
          next_w_wr_en   = 1'b0;
          next_z_wr_en   = 1'b0;
        end
        PH_READ: begin
          next_operand = reg_rd_data_i;
        end
        PH_PROCESS: begin
          unique case (op)
            FIDJ_OP_DEC, FIDJ_OP_DEC_SKIP: begin
              next_result = operand - ONE;
            end
            FIDJ_OP_INC: begin
              next_result = operand + ONE;
            end
            FIDJ_OP_NONE, FIDJ_OP_JUMP: begin
              next_result = result;
            end
          endcase
          // Strobes stand for the whole write phase only
          if (op == FIDJ_OP_DEC || op == FIDJ_OP_INC || op == FIDJ_OP_DEC_SKIP) begin
            next_reg_wr_en = dest_loc;
            next_w_wr_en   = !dest_loc;
          end
          if (op == FIDJ_OP_DEC || op == FIDJ_OP_INC) begin
            next_z_wr_en = 1'b1;
            next_zero    = (operand == ((op == FIDJ_OP_INC) ? 8'hff : ONE));
          end
        end
        PH_WRITE: begin
          next_reg_wr_en = 1'b0;
          next_w_wr_en   = 1'b0;
          next_z_wr_en   = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      operand   <= RST_DATA;
      result    <= RST_DATA;
      zero      <= 1'b0;
      reg_wr_en <= 1'b0;
      w_wr_en   <= 1'b0;
      z_wr_en   <= 1'b0;
    end else begin
      operand   <= next_operand;
      result    <= next_result;
      zero      <= next_zero;
      reg_wr_en <= next_reg_wr_en;
      w_wr_en   <= next_w_wr_en;
      z_wr_en   <= next_z_wr_en;
    end
  end

  // Program counter moves at the end of the write phase.
  // A skip steps by two and the following no-op cycle holds the count,
  // so the word discarded in it is fetched again next cycle and timing stays two cycles.
  always_comb begin
    next_pc    = pc;
    next_flush = flush;
    if (ce_i && last_phase) begin
      next_flush = 1'b0;
      if (nop_cycle) begin
        next_pc = pc;
      end else begin
        unique case (op)
          FIDJ_OP_JUMP: begin
            next_pc    = {program_counter_high_latch_i[LATCH_HI:LATCH_LO], ir[LIT_HI:0]};
            next_flush = 1'b1;
          end
          FIDJ_OP_DEC_SKIP: begin
            if (result == RST_DATA) begin
              next_pc    = pc + PC_SKIP_STEP;
              next_flush = 1'b1;
            end else begin
              next_pc = pc + PC_STEP;
            end
          end
          FIDJ_OP_NONE, FIDJ_OP_DEC, FIDJ_OP_INC: begin
            next_pc = pc + PC_STEP;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc    <= RST_PC;
      flush <= 1'b0;
    end else begin
      pc    <= next_pc;
      flush <= next_flush;
    end
  end

  assign pc_o        = pc;
  assign phase_o     = phase;
  assign reg_addr_o  = ir[ADDR_HI:0];
  assign reg_wr_en_o = reg_wr_en;
  assign w_wr_en_o   = w_wr_en;
  assign result_o    = result;
  assign z_o         = zero;
  assign z_wr_en_o   = z_wr_en;
  assign nop_cycle_o = nop_cycle;

endmodule

// >>> design/fidj_phase_seq.sv
// Phase sequencer: splits the core clock into instruction-cycle phases.
// Assumes a synchronous clock enable that freezes the count while low.
`timescale 1ns/1ps
module fidj_phase_seq
  import fidj_pkg::*;
#(
  parameter int unsigned PHASES = PHASE_COUNT,
  parameter int unsigned PW     = PHASE_W
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  output logic      [PW-1:0] phase_o,
  output logic               last_o
);

  localparam logic [PW-1:0] LAST_PHASE = PW'(PHASES - 1);

  logic [PW-1:0] phase;
  logic [PW-1:0] next_phase;

  always_comb begin
    next_phase = phase;
    if (ce_i) begin
      next_phase = (phase == LAST_PHASE) ? '0 : phase + PW'(1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase <= '0;
    end else begin
      phase <= next_phase;
    end
  end

  assign phase_o = phase;
  assign last_o  = (phase == LAST_PHASE);

endmodule

// >>> design/fidj_pkg.sv
// Constants and types for the file increment/decrement and jump execution block.
// Assumes a core that runs four phases per instruction cycle on one clock.
// Notes on behaviour
// - Decrement opcode subtracts one from addressed location
// - Destination bit zero writes W, one writes location
// - One word, one cycle: decode, read, compute, write; a jump or taken skip adds a no-op cycle
// - Increment adds one, sets zero flag on wrap
// - Decrement-skip on zero skips the next instruction
package fidj_pkg;

  localparam int unsigned INSTR_W      = 14;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned ADDR_W       = 7;
  localparam int unsigned PC_W         = 13;
  localparam int unsigned LATCH_W      = 8;
  localparam int unsigned PHASE_COUNT  = 4;
  localparam int unsigned PHASE_W      = 2;

  // Opcode field of the byte-oriented group sits in bits 13:8
  localparam int unsigned OPC_HI       = 13;
  localparam int unsigned OPC_LO       = 8;
  localparam logic [5:0]  OPC_DEC      = 6'h03;
  localparam logic [5:0]  OPC_INC      = 6'h0a;
  localparam logic [5:0]  OPC_DEC_SKIP = 6'h0b;

  // Jump opcode occupies bits 13:11
  localparam int unsigned JMP_OPC_LO   = 11;
  localparam logic [2:0]  OPC_JUMP     = 3'h5;

  // Field positions
  localparam int unsigned DEST_BIT     = 7;
  localparam int unsigned ADDR_HI      = 6;
  localparam int unsigned LIT_HI       = 10;
  localparam int unsigned LATCH_HI     = 4;
  localparam int unsigned LATCH_LO     = 3;

  // Destination select encoding
  localparam logic        DEST_W       = 1'b0;
  localparam logic        DEST_LOC     = 1'b1;

  // Phase numbers within an instruction cycle
  localparam logic [1:0]  PH_DECODE    = 2'h0;
  localparam logic [1:0]  PH_READ      = 2'h1;
  localparam logic [1:0]  PH_PROCESS   = 2'h2;
  localparam logic [1:0]  PH_WRITE     = 2'h3;

  // Reset values
  localparam logic [13:0] RST_INSTR    = 14'h0000;
  localparam logic [12:0] RST_PC       = 13'h0000;
  localparam logic [7:0]  RST_DATA     = 8'h00;

  // Program counter steps and the data step of one
  localparam logic [12:0] PC_STEP      = 13'h0001;
  localparam logic [12:0] PC_SKIP_STEP = 13'h0002;
  localparam logic [7:0]  ONE          = 8'h01;

  typedef enum logic [2:0] {
    FIDJ_OP_NONE,
    FIDJ_OP_DEC,
    FIDJ_OP_INC,
    FIDJ_OP_DEC_SKIP,
    FIDJ_OP_JUMP
  } fidj_op_t;

endpackage

// >>> dv/fidj_exec_chk.sv
// Checker for the increment/decrement/jump execution block, bound to its ports.
// Assumes one clock, async active-high reset, phases advancing only with ce_i.
`timescale 1ns/1ps
module fidj_exec_chk
  import fidj_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic [13:0] instr_i,
  input wire logic [7:0]  program_counter_high_latch_i,
  input wire logic [7:0]  reg_rd_data_i,
  input wire logic [12:0] pc_o,
  input wire logic [1:0]  phase_o,
  input wire logic        reg_wr_en_o,
  input wire logic        w_wr_en_o,
  input wire logic [7:0]  result_o,
  input wire logic        z_o,
  input wire logic        z_wr_en_o,
  input wire logic        nop_cycle_o
);
  logic [13:0] ir;
  logic [13:0] next_ir;
  logic [7:0]  op;
  logic [7:0]  next_op;
  logic [1:0]  hi;
  logic        end_c;
  assign hi = program_counter_high_latch_i[4:3];
  assign end_c = ce_i && phase_o == 2'h3 && !nop_cycle_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Every decode is captured; discarded words are never judged since end_c skips idle cycles
  always_comb begin
    next_ir = ir;
    next_op = op;
    if (ce_i && phase_o == 2'h0) next_ir = instr_i;
    if (ce_i && phase_o == 2'h1) next_op = reg_rd_data_i;
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ir <= 14'h0000;
      op <= 8'h00;
    end else begin
      ir <= next_ir;
      op <= next_op;
    end
  end
  sequence nop_run;
    nop_cycle_o [*4];
  endsequence
  strobe_excl_a: assert property (!(reg_wr_en_o && w_wr_en_o))
    else $error("both write strobes high");
  phase_step_a: assert property (ce_i |=> phase_o == $past(phase_o) + 2'h1)
    else $error("phase did not advance");
  freeze_all_a: assert property (!ce_i |=> $stable(phase_o) && $stable(pc_o))
    else $error("state moved while stalled");
  pc_quiet_a: assert property (ce_i && phase_o != 2'h3 |=> $stable(pc_o))
    else $error("pc moved before the write phase");
  strobe_phase_a: assert property (reg_wr_en_o || w_wr_en_o || z_wr_en_o |-> phase_o == 2'h3 && !nop_cycle_o)
    else $error("strobe outside write phase");
  dec_result_a: assert property (end_c && ir[13:8] == OPC_DEC |-> result_o == op - 8'h01 && z_wr_en_o
    && z_o == (result_o == 8'h00) && reg_wr_en_o == ir[7] && w_wr_en_o != ir[7]) else $error("bad decrement");
  inc_result_a: assert property (end_c && ir[13:8] == OPC_INC |-> result_o == op + 8'h01 && z_wr_en_o
    && z_o == (result_o == 8'h00) && reg_wr_en_o == ir[7] && w_wr_en_o != ir[7]) else $error("bad increment");
  skip_pc_a: assert property (end_c && ir[13:8] == OPC_DEC_SKIP |-> !z_wr_en_o && result_o == op - 8'h01
    ##1 pc_o == $past(pc_o) + (op == 8'h01 ? 13'h2 : 13'h1)) else $error("bad skip step");
  // Idle flag rises only at the decode edge of the following cycle
  skip_nop_a: assert property (end_c && ir[13:8] == OPC_DEC_SKIP && op == 8'h01 |=> ##1 nop_run)
    else $error("no idle cycle after skip");
  jump_pc_a: assert property (end_c && ir[13:11] == OPC_JUMP |=> pc_o == {$past(hi), ir[10:0]} ##1 nop_run)
    else $error("bad jump target");
  nop_hold_a: assert property (ce_i && phase_o == 2'h3 && nop_cycle_o |=> $stable(pc_o)
    ##1 (phase_o == 2'h0 || !nop_cycle_o))
    else $error("idle cycle moved pc");
endmodule
bind fidj_exec fidj_exec_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .instr_i(instr_i),
  .program_counter_high_latch_i(program_counter_high_latch_i),
  .reg_rd_data_i(reg_rd_data_i), .pc_o(pc_o), .phase_o(phase_o),
  .reg_wr_en_o(reg_wr_en_o), .w_wr_en_o(w_wr_en_o), .result_o(result_o), .z_o(z_o),
  .z_wr_en_o(z_wr_en_o), .nop_cycle_o(nop_cycle_o));

// >>> dv/testbench.sv
// Self-checking bench for the execution block, one task per scenario.
// Assumes the bench plays fetch memory and register file directly.
`timescale 1ns/1ps
module testbench import fidj_pkg::*;;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ce_i = 1'b1;
  logic [13:0] instr_i = 14'h0000;
  logic [7:0]  program_counter_high_latch_i = 8'h00;
  logic [7:0]  reg_rd_data_i = 8'h00;
  logic [12:0] pc_o;
  logic [1:0]  phase_o;
  logic [6:0]  reg_addr_o;
  logic        reg_wr_en_o;
  logic        w_wr_en_o;
  logic [7:0]  result_o;
  logic        z_o;
  logic        z_wr_en_o;
  logic        nop_cycle_o;
  logic [12:0] pc = 13'h0000;
  int          n_errors = 0;
  int          compares = 0;
  fidj_exec i_fidj_exec (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .instr_i(instr_i),
    .program_counter_high_latch_i(program_counter_high_latch_i),
    .reg_rd_data_i(reg_rd_data_i), .pc_o(pc_o), .phase_o(phase_o), .reg_addr_o(reg_addr_o),
    .reg_wr_en_o(reg_wr_en_o), .w_wr_en_o(w_wr_en_o), .result_o(result_o), .z_o(z_o),
    .z_wr_en_o(z_wr_en_o), .nop_cycle_o(nop_cycle_o));
  always #2.5 clk_i = ~clk_i;
  task automatic finish_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Entered just after the edge that opens phase 0; st = {nop, loc, w, zero}
  task automatic run(input logic [13:0] ins, input logic [7:0] rd, input logic [7:0] res,
                     input logic [3:0] st, input logic [12:0] npc, input int stall);
    instr_i = ins;
    reg_rd_data_i = rd;
    tick(1);
    if (st[2:1] != 2'h0) chk("reg_addr", {9'h000, ins[6:0]}, {9'h000, reg_addr_o});
    if (stall > 0) begin
      ce_i = 1'b0;
      tick(stall);
      chk("stall_phase", 16'h0001, {14'h0000, phase_o});
      ce_i = 1'b1;
    end
    tick(2);
    chk("strobes", {12'h000, st}, {12'h000, nop_cycle_o, reg_wr_en_o, w_wr_en_o, z_wr_en_o});
    if (st[2:1] != 2'h0) chk("result", {8'h00, res}, {8'h00, result_o});
    if (st[0]) chk("zero", {15'h0000, res == 8'h00}, {15'h0000, z_o});
    tick(1);
    chk("pc", {3'h0, npc}, {3'h0, pc_o});
    pc = npc;
  endtask
  task automatic t_dec;
    run(14'h0385, 8'h01, 8'h00, 4'b0101, pc + 13'h1, 0);
    run(14'h037f, 8'h00, 8'hff, 4'b0011, pc + 13'h1, 3);
  endtask
  task automatic t_inc;
    run(14'h0a85, 8'hff, 8'h00, 4'b0101, pc + 13'h1, 0);
    run(14'h0a01, 8'h12, 8'h13, 4'b0011, pc + 13'h1, 0);
  endtask
  task automatic t_skip;
    run(14'h0b90, 8'h05, 8'h04, 4'b0100, pc + 13'h1, 0);
    run(14'h0b10, 8'h01, 8'h00, 4'b0010, pc + 13'h2, 0);
    run(14'h0385, 8'h07, 8'h00, 4'b1000, pc, 0);
  endtask
  task automatic t_jump;
    program_counter_high_latch_i = 8'h18;
    run(14'h2aaa, 8'h00, 8'h00, 4'b0000, 13'h1aaa, 0);
    run(14'h0385, 8'h00, 8'h00, 4'b1000, pc, 0);
    program_counter_high_latch_i = 8'he7;
    run(14'h2fff, 8'h00, 8'h00, 4'b0000, 13'h07ff, 0);
    run(14'h0a85, 8'h00, 8'h00, 4'b1000, pc, 0);
  endtask
  // Unlisted opcode, then a reset landing mid-instruction
  task automatic t_misc;
    run(14'h0700, 8'h33, 8'h00, 4'b0000, pc + 13'h1, 0);
    instr_i = 14'h0385;
    tick(3);
    rst_i = 1'b1;
    tick(1);
    chk("rst_pc", 16'h0000, {3'h0, pc_o});
    chk("rst_out", 16'h0000, {10'h000, phase_o, reg_wr_en_o, w_wr_en_o, z_wr_en_o, nop_cycle_o});
    rst_i = 1'b0;
    pc = 13'h0000;
    run(14'h0b81, 8'h01, 8'h00, 4'b0100, pc + 13'h2, 0);
  endtask
  initial begin
    #2000;
    n_errors++;
    finish_test();
  end
  initial begin
    tick(2);
    rst_i = 1'b0;
    t_dec();
    t_inc();
    t_skip();
    t_jump();
    t_misc();
    tick(4);
    finish_test();
  end
endmodule
